/* File: rtl/aicp_pkg.sv */
package aicp_pkg;
  // widths of the register port and peak codes
  localparam int ADDR_W = 4;
  localparam int DATA_W = 10;
  localparam int PEAK_W = 6;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_CFG  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_SERIAL_CFG = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_CFG  = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_LEFT_PEAK  = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_RIGHT_PEAK = 4'h4;

  // clock config fields
  localparam int RATIO_LSB   = 0;
  localparam int PEAK_EN_BIT = 2;
  // serial config fields
  localparam int FMT_LSB     = 0;
  localparam int SLAVE_BIT   = 2;
  localparam int MOD_EN_BIT  = 3;
  // input config fields
  localparam int R_PIN_BIT   = 0;
  localparam int R_BUF_BIT   = 1;
  localparam int L_PIN_BIT   = 2;
  localparam int L_BUF_BIT   = 3;
  localparam int R_SE_BIT    = 4;
  localparam int L_SE_BIT    = 5;
  localparam int DIV_LSB     = 6;

  // power-on values
  localparam logic [DATA_W-1:0] CLOCK_CFG_RESET  = 10'h000;
  localparam logic [DATA_W-1:0] SERIAL_CFG_RESET = 10'h000;
  localparam logic [DATA_W-1:0] INPUT_CFG_RESET  = 10'h000;
  localparam logic [DATA_W-1:0] READ_ZERO        = 10'h000;
  localparam logic [PEAK_W-1:0] PEAK_CLEARED     = 6'h00;

  // divider codes
  typedef enum logic [1:0] {
    DIV_BY1     = 2'h0,
    DIV_BY2     = 2'h1,
    DIV_BY3     = 2'h2,
    DIV_BY1_ALT = 2'h3
  } aicp_div_t;

  // serial interface formats
  typedef enum logic [1:0] {
    FMT_I2S   = 2'h0,
    FMT_RIGHT = 2'h1,
    FMT_DSP   = 2'h2,
    FMT_LEFT  = 2'h3
  } aicp_format_t;

  // master clock ratios
  localparam logic [1:0] RATIO_256 = 2'h0;
  localparam logic [1:0] RATIO_512 = 2'h1;
endpackage : aicp_pkg

/* File: rtl/aicp_clock_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module aicp_clock_divider (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire aicp_pkg::aicp_div_t clock_divide_code,
  output logic                  internal_master_clock
);
  import aicp_pkg::*;

  logic [1:0] count;
  logic [1:0] next_count;
  logic       next_tick;

  // last count value before each internal clock tick, one less than cycles per tick
  function automatic logic [1:0] last_count(input aicp_div_t code);
    unique case (code)
      DIV_BY2: last_count = 2'h1;
      DIV_BY3: last_count = 2'h2;
      DIV_BY1, DIV_BY1_ALT: last_count = 2'h0;
    endcase
  endfunction : last_count

  always_comb begin
    if (count >= last_count(clock_divide_code)) begin
      next_count = 2'h0;
    end else begin
      next_count = count + 2'h1;
    end
    next_tick = (next_count == 2'h0);
  end

  // count and tick registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count                 <= 2'h0;
      internal_master_clock <= 1'b0;
    end else begin
      count                 <= next_count;
      internal_master_clock <= next_tick;
    end
  end

  property p_div_two;
    @(posedge clk_sys) disable iff (!reset_n)
    (clock_divide_code == DIV_BY2 && $past(clock_divide_code) == DIV_BY2 && internal_master_clock)
      ##1 (clock_divide_code == DIV_BY2) |-> !internal_master_clock ##1 internal_master_clock;
  endproperty
  a_div_two: assert property (p_div_two) else $error("divide by two spacing wrong");

  property p_div_three;
    @(posedge clk_sys) disable iff (!reset_n)
    (clock_divide_code == DIV_BY3 && $past(clock_divide_code) == DIV_BY3 && internal_master_clock)
      ##1 (clock_divide_code == DIV_BY3) |-> !internal_master_clock ##1 !internal_master_clock;
  endproperty
  a_div_three: assert property (p_div_three) else $error("divide by three spacing wrong");
endmodule : aicp_clock_divider
`default_nettype wire

/* File: rtl/aicp_ctrl.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - single-ended bit set takes one pin chosen by mux bit, else differential
// - divider code 00 and 11 pass clock, 01 halves it, 10 thirds it
// - left peak at address 3, code in bits 5..0, bits 9..6 zero
// - right peak at address 4, code in six low bits, zeros above
// - with peak tracking on, each channel's peak is held in its register
// - peak code sits in the six low bits of a ten-bit word
// - peak code counts dB below full scale, zero is full scale
// - reading a peak register clears it; later conversions refill it
// - strap select high takes master/slave, ratio, format from pins
// - strap slave pin low drives frame and bit clocks, high receives them
// - strap ratio pin low expects 256 times, high expects 512 times
// - strap format pins replace the two serial format bits
// - format 00 I2S default, 01 right, 10 DSP, 11 left justified
// - under straps every other function stays at power-on default
// - modulator mode drives four data pins; serial output becomes sample clock
// - left data valid while sample clock low, right while high
// - modulator mode passes raw modulator words instead of PCM
// - divider code occupies bits 7..6 of input config at address 2
module aicp_ctrl (
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  // register port
  input  wire logic [aicp_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [aicp_pkg::DATA_W-1:0]   reg_write_data,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  output logic      [aicp_pkg::DATA_W-1:0]   reg_read_data,
  // strap pins
  input  wire logic                          hardware_strap_select,
  input  wire logic                          strap_slave,
  input  wire logic                          strap_ratio,
  input  wire logic [1:0]                    strap_format,
  // conversion results
  input  wire logic                          conv_valid,
  input  wire logic [aicp_pkg::PEAK_W-1:0]   conv_left_level,
  input  wire logic [aicp_pkg::PEAK_W-1:0]   conv_right_level,
  // modulator words and serial control data
  input  wire logic [3:0]                    mod_left_data,
  input  wire logic [3:0]                    mod_right_data,
  input  wire logic                          control_serial_data,
  // effective configuration
  output logic                               left_single_ended_on,
  output logic                               right_single_ended_on,
  output logic                               left_input_pin_choice,
  output logic                               right_input_pin_choice,
  output logic                               left_buffer_off,
  output logic                               right_buffer_off,
  output logic                               peak_track_enable,
  output logic                               slave_mode,
  output logic                               serial_clocks_oe,
  output logic      [1:0]                    clock_ratio_code,
  output aicp_pkg::aicp_format_t             serial_format_code,
  output logic                               modulator_bypass_enable,
  output logic                               internal_master_clock,
  // modulator pins
  output logic                               modulator_sample_clock,
  output logic      [3:0]                    modulator_data,
  output logic                               modulator_data_oe,
  output logic                               control_serial_output
);
  import aicp_pkg::*;

  logic [DATA_W-1:0] clock_cfg, next_clock_cfg;
  logic [DATA_W-1:0] serial_cfg, next_serial_cfg;
  logic [DATA_W-1:0] input_cfg, next_input_cfg;
  logic [DATA_W-1:0] next_read_data;
  logic [PEAK_W-1:0] left_peak_level, next_left_peak_level;
  logic [PEAK_W-1:0] right_peak_level, next_right_peak_level;
  logic              left_fresh, next_left_fresh;
  logic              right_fresh, next_right_fresh;
  logic              next_mod_clk;
  logic [3:0]        next_mod_data;
  logic [DATA_W-1:0] input_eff;
  aicp_div_t         divide_code;
  logic              read_left, read_right;

  // next peak value: a fresh register takes any code, else the louder one
  function automatic logic [PEAK_W-1:0] peak_merge(input logic [PEAK_W-1:0] held,
                                                   input logic              fresh,
                                                   input logic [PEAK_W-1:0] level);
    if (fresh || level < held) begin
      peak_merge = level;
    end else begin
      peak_merge = held;
    end
  endfunction : peak_merge

  // low word of a peak readback
  function automatic logic [DATA_W-1:0] peak_word(input logic [PEAK_W-1:0] code);
    peak_word = {{(DATA_W-PEAK_W){1'b0}}, code};
  endfunction : peak_word

  // configuration writes
  always_comb begin
    next_clock_cfg  = clock_cfg;
    next_serial_cfg = serial_cfg;
    next_input_cfg  = input_cfg;
    if (reg_write) begin
      unique case (reg_addr)
        ADDR_CLOCK_CFG:  next_clock_cfg  = reg_write_data;
        ADDR_SERIAL_CFG: next_serial_cfg = reg_write_data;
        ADDR_INPUT_CFG:  next_input_cfg  = reg_write_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clock_cfg  <= CLOCK_CFG_RESET;
      serial_cfg <= SERIAL_CFG_RESET;
      input_cfg  <= INPUT_CFG_RESET;
    end else begin
      clock_cfg  <= next_clock_cfg;
      serial_cfg <= next_serial_cfg;
      input_cfg  <= next_input_cfg;
    end
  end

  always_comb begin
    if (hardware_strap_select) begin
      slave_mode              = strap_slave;
      clock_ratio_code        = strap_ratio ? RATIO_512 : RATIO_256;
      serial_format_code      = aicp_format_t'(strap_format);
      input_eff               = INPUT_CFG_RESET;
      peak_track_enable       = CLOCK_CFG_RESET[PEAK_EN_BIT];
      modulator_bypass_enable = SERIAL_CFG_RESET[MOD_EN_BIT];
    end else begin
      slave_mode              = serial_cfg[SLAVE_BIT];
      clock_ratio_code        = clock_cfg[RATIO_LSB +: 2];
      serial_format_code      = aicp_format_t'(serial_cfg[FMT_LSB +: 2]);
      input_eff               = input_cfg;
      peak_track_enable       = clock_cfg[PEAK_EN_BIT];
      modulator_bypass_enable = serial_cfg[MOD_EN_BIT];
    end
  end

  assign left_single_ended_on   = input_eff[L_SE_BIT];
  assign right_single_ended_on  = input_eff[R_SE_BIT];
  assign left_input_pin_choice  = input_eff[L_PIN_BIT];
  assign right_input_pin_choice = input_eff[R_PIN_BIT];
  // buffer bypass for direct modulator drive
  assign left_buffer_off        = input_eff[L_BUF_BIT];
  assign right_buffer_off       = input_eff[R_BUF_BIT];
  assign serial_clocks_oe       = !slave_mode;
  assign divide_code            = aicp_div_t'(input_eff[DIV_LSB +: 2]);

  // internal clock tick
  aicp_clock_divider u_divider (
    .clk_sys               (clk_sys),
    .reset_n               (reset_n),
    .clock_divide_code     (divide_code),
    .internal_master_clock (internal_master_clock)
  );

  assign read_left  = reg_read && (reg_addr == ADDR_LEFT_PEAK);
  assign read_right = reg_read && (reg_addr == ADDR_RIGHT_PEAK);

  always_comb begin
    next_left_peak_level  = left_peak_level;
    next_right_peak_level = right_peak_level;
    next_left_fresh       = left_fresh;
    next_right_fresh      = right_fresh;
    if (read_left) begin
      next_left_peak_level = PEAK_CLEARED;
      next_left_fresh      = 1'b1;
    end
    if (read_right) begin
      next_right_peak_level = PEAK_CLEARED;
      next_right_fresh      = 1'b1;
    end
    // a conversion in the read cycle wins over the clear
    if (peak_track_enable && conv_valid) begin
      next_left_peak_level  = peak_merge(left_peak_level, left_fresh || read_left,
                                         conv_left_level);
      next_right_peak_level = peak_merge(right_peak_level, right_fresh || read_right,
                                         conv_right_level);
      next_left_fresh       = 1'b0;
      next_right_fresh      = 1'b0;
    end
  end

  always_comb begin
    next_read_data = READ_ZERO;
    if (reg_read) begin
      unique case (reg_addr)
        ADDR_CLOCK_CFG:  next_read_data = clock_cfg;
        ADDR_SERIAL_CFG: next_read_data = serial_cfg;
        ADDR_INPUT_CFG:  next_read_data = input_cfg;
        ADDR_LEFT_PEAK:  next_read_data = peak_word(left_peak_level);
        ADDR_RIGHT_PEAK: next_read_data = peak_word(right_peak_level);
        default:         next_read_data = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      left_peak_level  <= PEAK_CLEARED;
      right_peak_level <= PEAK_CLEARED;
      left_fresh       <= 1'b1;
      right_fresh      <= 1'b1;
      reg_read_data    <= READ_ZERO;
    end else begin
      left_peak_level  <= next_left_peak_level;
      right_peak_level <= next_right_peak_level;
      left_fresh       <= next_left_fresh;
      right_fresh      <= next_right_fresh;
      reg_read_data    <= next_read_data;
    end
  end

  // sample clock at half the internal rate
  // left in low phase, right in high
  always_comb begin
    next_mod_clk  = 1'b0;
    next_mod_data = 4'h0;
    if (modulator_bypass_enable) begin
      next_mod_clk  = internal_master_clock ? !modulator_sample_clock : modulator_sample_clock;
      next_mod_data = next_mod_clk ? mod_right_data : mod_left_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      modulator_sample_clock <= 1'b0;
      modulator_data         <= 4'h0;
    end else begin
      modulator_sample_clock <= next_mod_clk;
      modulator_data         <= next_mod_data;
    end
  end

  assign modulator_data_oe     = modulator_bypass_enable;
  assign control_serial_output = modulator_bypass_enable ? modulator_sample_clock
                                                         : control_serial_data;

  property p_left_clear;
    @(posedge clk_sys) disable iff (!reset_n)
    (read_left && !(peak_track_enable && conv_valid)) |=> (left_peak_level == PEAK_CLEARED);
  endproperty
  a_left_clear: assert property (p_left_clear) else $error("left peak not cleared");

  property p_keep_loudest;
    @(posedge clk_sys) disable iff (!reset_n)
    (peak_track_enable && conv_valid && !left_fresh && !read_left
     && conv_left_level >= left_peak_level) |=> $stable(left_peak_level);
  endproperty
  a_keep_loudest: assert property (p_keep_loudest) else $error("quieter code replaced peak");

  property p_take_louder;
    @(posedge clk_sys) disable iff (!reset_n)
    (peak_track_enable && conv_valid && conv_right_level < right_peak_level)
      |=> (right_peak_level == $past(conv_right_level));
  endproperty
  a_take_louder: assert property (p_take_louder) else $error("louder code not taken");

  property p_left_word;
    @(posedge clk_sys) disable iff (!reset_n)
    read_left |=> (reg_read_data == {4'h0, $past(left_peak_level)});
  endproperty
  a_left_word: assert property (p_left_word) else $error("left peak readback wrong");

  property p_right_word;
    @(posedge clk_sys) disable iff (!reset_n)
    read_right |=> (reg_read_data[9:6] == 4'h0)
                   && (reg_read_data[5:0] == $past(right_peak_level));
  endproperty
  a_right_word: assert property (p_right_word) else $error("right peak readback wrong");

  property p_strap_pins;
    @(posedge clk_sys) disable iff (!reset_n)
    hardware_strap_select |-> (slave_mode == strap_slave) && (serial_clocks_oe == !strap_slave)
                              && (clock_ratio_code == (strap_ratio ? RATIO_512 : RATIO_256))
                              && (serial_format_code == strap_format);
  endproperty
  a_strap_pins: assert property (p_strap_pins) else $error("strap pins not obeyed");

  property p_strap_default;
    @(posedge clk_sys) disable iff (!reset_n)
    hardware_strap_select |-> !modulator_bypass_enable && !peak_track_enable
                              && !left_single_ended_on && !right_buffer_off;
  endproperty
  a_strap_default: assert property (p_strap_default) else $error("strap mode not default");

  property p_mod_phase;
    @(posedge clk_sys) disable iff (!reset_n)
    ($past(modulator_bypass_enable) && modulator_bypass_enable)
      |-> (modulator_data == (modulator_sample_clock ? $past(mod_right_data)
                                                     : $past(mod_left_data)));
  endproperty
  a_mod_phase: assert property (p_mod_phase) else $error("modulator phase data wrong");

  property p_mod_pin;
    @(posedge clk_sys) disable iff (!reset_n)
    modulator_bypass_enable |-> modulator_data_oe
                                && (control_serial_output == modulator_sample_clock);
  endproperty
  a_mod_pin: assert property (p_mod_pin) else $error("modulator pins not redefined");
endmodule : aicp_ctrl
`default_nettype wire

/* File: dv/aicp_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// remodulator side: supplies modulator words, samples each phase of the output stream
module aicp_far_model #(
  parameter logic [3:0] LEFT_WORD  = 4'hA,
  parameter logic [3:0] RIGHT_WORD = 4'h5
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       modulator_sample_clock,
  input  wire logic [3:0] modulator_data,
  input  wire logic       modulator_data_oe,
  output logic      [3:0] mod_left_data,
  output logic      [3:0] mod_right_data,
  output logic      [3:0] got_left,
  output logic      [3:0] got_right
);
  // fixed words from the two modulators
  assign mod_left_data  = LEFT_WORD;
  assign mod_right_data = RIGHT_WORD;

  // left in low phase, right in high phase
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      got_left  <= 4'h0;
      got_right <= 4'h0;
    end else if (modulator_data_oe) begin
      if (!modulator_sample_clock) begin
        got_left <= modulator_data;
      end else begin
        got_right <= modulator_data;
      end
    end
  end
endmodule : aicp_far_model
`default_nettype wire

/* File: dv/aicp_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module aicp_ctrl_tb_top;
  import aicp_pkg::*;
  logic clk_sys, reset_n, reg_write, reg_read, conv_valid, control_serial_data;
  logic [3:0] reg_addr, mod_left_data, mod_right_data, modulator_data, got_left, got_right;
  logic [9:0] reg_read_data, reg_write_data;
  logic hardware_strap_select, strap_slave, strap_ratio, internal_master_clock;
  logic [1:0] strap_format, clock_ratio_code;
  logic [5:0] conv_left_level, conv_right_level;
  logic left_single_ended_on, right_single_ended_on, left_input_pin_choice, left_buffer_off;
  logic right_input_pin_choice, right_buffer_off, peak_track_enable, slave_mode;
  logic serial_clocks_oe, modulator_bypass_enable, modulator_sample_clock;
  logic modulator_data_oe, control_serial_output;
  aicp_format_t serial_format_code;
  int num_errors, checked, cycles, n;

  aicp_ctrl uut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_write_data(reg_write_data), .reg_write(reg_write), .reg_read(reg_read),
    .reg_read_data(reg_read_data), .hardware_strap_select(hardware_strap_select),
    .strap_slave(strap_slave), .strap_ratio(strap_ratio), .strap_format(strap_format),
    .conv_valid(conv_valid), .conv_left_level(conv_left_level),
    .conv_right_level(conv_right_level), .mod_left_data(mod_left_data),
    .mod_right_data(mod_right_data), .control_serial_data(control_serial_data),
    .left_single_ended_on(left_single_ended_on), .right_single_ended_on(right_single_ended_on),
    .left_input_pin_choice(left_input_pin_choice),
    .right_input_pin_choice(right_input_pin_choice), .left_buffer_off(left_buffer_off),
    .right_buffer_off(right_buffer_off), .peak_track_enable(peak_track_enable),
    .slave_mode(slave_mode), .serial_clocks_oe(serial_clocks_oe),
    .clock_ratio_code(clock_ratio_code), .serial_format_code(serial_format_code),
    .modulator_bypass_enable(modulator_bypass_enable),
    .internal_master_clock(internal_master_clock),
    .modulator_sample_clock(modulator_sample_clock), .modulator_data(modulator_data),
    .modulator_data_oe(modulator_data_oe), .control_serial_output(control_serial_output));

  aicp_far_model far (.clk_sys(clk_sys), .reset_n(reset_n),
    .modulator_sample_clock(modulator_sample_clock), .modulator_data(modulator_data),
    .modulator_data_oe(modulator_data_oe), .mod_left_data(mod_left_data),
    .mod_right_data(mod_right_data), .got_left(got_left), .got_right(got_right));

  // clock at 25 MHz
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [9:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_write_data <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [9:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    chk("read data", reg_read_data, exp);
  endtask : rd

  task automatic conv(input logic [5:0] l, input logic [5:0] r);
    @(posedge clk_sys);
    conv_valid <= 1'b1;
    conv_left_level <= l;
    conv_right_level <= r;
    @(posedge clk_sys);
    conv_valid <= 1'b0;
  endtask : conv

  // counts cycles with the tick high, or sample clock changes, over 12 cycles
  task automatic count(input bit sclk, output int k);
    logic prev;
    k = 0;
    #1;
    prev = control_serial_output;
    repeat (12) begin
      @(posedge clk_sys);
      #1;
      if (sclk && control_serial_output !== prev) k++;
      if (!sclk && internal_master_clock === 1'b1) k++;
      prev = control_serial_output;
    end
  endtask : count

  task automatic results();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // main sequence
  initial begin
    reset_n = 1'b0;
    {reg_write, reg_read, conv_valid, control_serial_data} = 4'h0;
    {reg_addr, reg_write_data, conv_left_level, conv_right_level} = 26'h0;
    {hardware_strap_select, strap_slave, strap_ratio, strap_format} = 5'h0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(ADDR_SERIAL_CFG, 10'h000);
    chk("format", 10'(serial_format_code), 10'(FMT_I2S));
    chk("clocks oe", 10'(serial_clocks_oe), 10'h001);
    conv(6'h05, 6'h05);
    rd(ADDR_LEFT_PEAK, 10'h000);
    wr(ADDR_CLOCK_CFG, 10'h005);
    chk("peak enable", 10'(peak_track_enable), 10'h001);
    chk("ratio", 10'(clock_ratio_code), 10'(RATIO_512));
    conv(6'h0A, 6'h14);
    conv(6'h07, 6'h0F);
    conv(6'h3F, 6'h3F);
    rd(ADDR_LEFT_PEAK, 10'h007);
    rd(ADDR_RIGHT_PEAK, 10'h00F);
    rd(ADDR_LEFT_PEAK, 10'h000);
    conv(6'h28, 6'h3F);
    rd(ADDR_LEFT_PEAK, 10'h028);
    rd(ADDR_RIGHT_PEAK, 10'h03F);
    wr(ADDR_LEFT_PEAK, 10'h3FF);
    rd(ADDR_LEFT_PEAK, 10'h000);
    rd(4'hF, 10'h000);
    // input selection fields
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_INPUT_CFG, (i == 0) ? 10'h015 : 10'h02A);
      chk("input sel", {4'h0, left_single_ended_on, right_single_ended_on, left_buffer_off,
        left_input_pin_choice, right_buffer_off, right_input_pin_choice},
        (i == 0) ? 10'h015 : 10'h02A);
      rd(ADDR_INPUT_CFG, (i == 0) ? 10'h015 : 10'h02A);
    end
    // every divider code; software would pick one giving 256x
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_INPUT_CFG, 10'(d << 6));
      repeat (3) @(posedge clk_sys);
      count(1'b0, n);
      chk("ticks", 10'(n), (d == 1) ? 10'd6 : (d == 2) ? 10'd4 : 10'd12);
    end
    // every serial format, slave on odd codes
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_SERIAL_CFG, 10'(f | ((f & 1) << 2)));
      chk("format", 10'(serial_format_code), 10'(f));
      chk("slave", 10'(serial_clocks_oe), 10'(~f & 1));
    end
    // modulator stream with buffers off
    wr(ADDR_SERIAL_CFG, 10'h008);
    for (int d = 0; d < 2; d++) begin
      wr(ADDR_INPUT_CFG, 10'((d << 6) | 10'h00A));
      repeat (4) @(posedge clk_sys);
      count(1'b1, n);
      chk("sample clock", 10'(n), d ? 10'd6 : 10'd12);
      chk("control_serial_output", 10'(control_serial_output), 10'(modulator_sample_clock));
    end
    chk("left word", 10'(got_left), 10'h00A);
    chk("right word", 10'(got_right), 10'h005);
    chk("data oe", 10'(modulator_data_oe), 10'h001);
    wr(ADDR_SERIAL_CFG, 10'h000);
    @(posedge clk_sys);
    control_serial_data <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("control_serial_output normal", 10'(control_serial_output), 10'h001);
    chk("data off", {5'h0, modulator_data_oe, modulator_data}, 10'h000);
    // strap control over written registers
    wr(ADDR_SERIAL_CFG, 10'h00D);
    wr(ADDR_INPUT_CFG, 10'h03F);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      hardware_strap_select <= 1'b1;
      strap_slave <= (s == 0);
      strap_ratio <= (s == 0);
      strap_format <= (s == 0) ? 2'h3 : 2'h2;
      @(posedge clk_sys);
      #1;
      chk("strap slave", {8'h0, slave_mode, serial_clocks_oe}, (s == 0) ? 10'h2 : 10'h1);
      chk("strap ratio", 10'(clock_ratio_code), (s == 0) ? 10'(RATIO_512) : 10'(RATIO_256));
      chk("strap fmt", 10'(serial_format_code), (s == 0) ? 10'h3 : 10'h2);
      chk("defaults", {6'h0, left_single_ended_on, left_buffer_off, peak_track_enable,
        modulator_bypass_enable}, 10'h000);
    end
    conv(6'h09, 6'h09);
    rd(ADDR_LEFT_PEAK, 10'h000);
    results();
  end
endmodule : aicp_ctrl_tb_top
`default_nettype wire
